// ===== hdl/sd_path_pkg.sv
// Shared constants and types for the sigma-delta decimation path
`default_nettype none
package sd_path_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_CH = 6;
  localparam int WORD_W = 16;
  localparam int RES_W = 15;
  localparam int CIC_W = 25;
  localparam int STAGE_COUNT = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int GAIN_W = 6;
  localparam int BITCNT_W = 4;

  // ==========================================================================
  // Rates
  localparam int MOD_DIV = 8;
  localparam logic [2:0] MOD_DIV_LAST = 3'(MOD_DIV - 1);
  localparam int BASE_OSR = 32;
  localparam int BITS_PER_STAGE_BASE = 5;
  localparam int MCLK_DIV_MAX = 5;

  // ==========================================================================
  // Control bit positions
  localparam int CRA_DATA_BIT = 0;
  localparam int CRA_MIXED_BIT = 1;
  localparam int CRB_RATE_LSB = 0;
  localparam int CRB_SCLK_LSB = 2;
  localparam int CRB_MCLK_LSB = 4;
  localparam int CRC_REF_BIT = 6;
  localparam int GAIN_LO_LSB = 0;
  localparam int GAIN_HI_LSB = 4;

  // ==========================================================================
  // Values
  localparam logic [WORD_W-1:0] POS_FULL_SCALE = 16'h7fff;
  localparam logic [RES_W-1:0] RES_MAX = 15'h3fff;
  localparam logic FLAG_DATA = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [CIC_W-1:0] CIC_RST = 25'h0000000;
  localparam logic [GAIN_W-1:0] GAIN_DB [8] = '{6'h00, 6'h06, 6'h0c, 6'h12,
                                               6'h14, 6'h1a, 6'h20, 6'h26};

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [2:0] mclk_div;
    logic [1:0] sclk_rate;
    logic [1:0] rate;
  } timing_cfg_t;

  typedef struct packed {
    logic data_mode;
    logic mixed_mode;
  } mode_t;

  typedef enum logic {SER_IDLE, SER_SHIFT} ser_state_t;

endpackage
`default_nettype wire

// ===== hdl/sample_fifo.sv
// Sample FIFO with registered read data and valid/ready on both sides
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (PTR_W+1)'(DEPTH));
  assign push = in_valid_i && in_ready_o;
  // Refill the output register whenever it is free or being taken
  assign pop = (count != '0) && (!out_valid_o || out_ready_i);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rd_ptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule // sample_fifo
`default_nettype wire

// ===== hdl/sd_decimation_path.sv
// Six-channel sinc-cubed decimation path with serial sample output
`default_nettype none
module sd_decimation_path
  import sd_path_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [NUM_CH-1:0] modulator_bit_i,
  input wire logic [7:0] control_reg_a_i,
  input wire logic [7:0] control_reg_b_i,
  input wire logic [7:0] control_reg_c_i,
  input wire logic [7:0] control_reg_d_i,
  input wire logic [7:0] control_reg_e_i,
  input wire logic [7:0] control_reg_f_i,
  input wire logic host_sdi_i,
  output logic [NUM_CH-1:0][GAIN_W-1:0] gain_db_o,
  output logic reference_output_enable_o,
  output logic serial_clk_o,
  output logic serial_data_o,
  output logic frame_sync_o,
  output logic [WORD_W-1:0] rx_word_o,
  output logic rx_valid_o,
  output logic sample_event_o,
  output logic overrun_o
);

  // ==========================================================================
  // Configuration
  timing_cfg_t cfg;
  mode_t mode;
  logic [7:0] gain_regs [3];

  assign cfg.rate = control_reg_b_i[CRB_RATE_LSB +: 2];
  assign cfg.sclk_rate = control_reg_b_i[CRB_SCLK_LSB +: 2];
  assign cfg.mclk_div = control_reg_b_i[CRB_MCLK_LSB +: 3];
  assign mode.data_mode = control_reg_a_i[CRA_DATA_BIT];
  assign mode.mixed_mode = control_reg_a_i[CRA_DATA_BIT] && control_reg_a_i[CRA_MIXED_BIT];
  assign gain_regs[0] = control_reg_d_i;
  assign gain_regs[1] = control_reg_e_i;
  assign gain_regs[2] = control_reg_f_i;

  // ==========================================================================
  // Gain decode and reference enable
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gain_db_o <= '0;
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        gain_db_o[ch] <= (ch % 2 == 0) ? GAIN_DB[gain_regs[ch/2][GAIN_LO_LSB +: 3]]
                                       : GAIN_DB[gain_regs[ch/2][GAIN_HI_LSB +: 3]];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      reference_output_enable_o <= 1'b0;
    end else begin
      reference_output_enable_o <= control_reg_c_i[CRC_REF_BIT];
    end
  end

  // ==========================================================================
  // Clock enables
  logic [2:0] mclk_cnt;
  logic [2:0] mclk_last;
  logic dm_en;
  logic [2:0] mod_cnt;
  logic mod_en;
  logic [7:0] dec_cnt;
  logic [7:0] dec_last;
  logic dec_fire;
  logic [2:0] sclk_cnt;
  logic [2:0] sclk_mask;
  logic half_tick;

  assign mclk_last = (cfg.mclk_div >= 3'(MCLK_DIV_MAX)) ? 3'(MCLK_DIV_MAX - 1) : cfg.mclk_div;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mclk_cnt <= '0;
      dm_en <= 1'b0;
    end else begin
      dm_en <= (mclk_cnt >= mclk_last);
      mclk_cnt <= (mclk_cnt >= mclk_last) ? '0 : mclk_cnt + 1'b1;
    end
  end

  // Sampling enable at divided master clock (dm_en) / 8
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mod_cnt <= '0;
    end else if (dm_en) begin
      mod_cnt <= mod_cnt + 1'b1;
    end
  end
  assign mod_en = dm_en && (mod_cnt == MOD_DIV_LAST);

  // Ratio 32, 64, 128 or 256
  assign dec_last = 8'((BASE_OSR << cfg.rate) - 1);
  assign dec_fire = mod_en && (dec_cnt >= dec_last);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      dec_cnt <= '0;
    end else if (mod_en) begin
      dec_cnt <= (dec_cnt >= dec_last) ? '0 : dec_cnt + 1'b1;
    end
  end

  assign sclk_mask = 3'((4'h1 << cfg.sclk_rate) - 4'h1);
  assign half_tick = dm_en && ((sclk_cnt & sclk_mask) == sclk_mask);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sclk_cnt <= '0;
    end else if (dm_en) begin
      sclk_cnt <= sclk_cnt + 1'b1;
    end
  end

  // ==========================================================================
  // Input synchronisers
  logic [NUM_CH-1:0] mod_meta;
  logic [NUM_CH-1:0] mod_sync;
  logic sdi_meta;
  logic sdi_sync;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mod_meta <= '0;
      mod_sync <= '0;
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
    end else begin
      mod_meta <= modulator_bit_i;
      mod_sync <= mod_meta;
      sdi_meta <= host_sdi_i;
      sdi_sync <= sdi_meta;
    end
  end

  // ==========================================================================
  // Sinc-cubed decimators
  logic [WORD_W-1:0] ch_word [NUM_CH];
  logic sample_pending;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sample_pending <= 1'b0;
    end else begin
      sample_pending <= dec_fire;
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    logic [CIC_W-1:0] integ [STAGE_COUNT];
    logic [CIC_W-1:0] delay [STAGE_COUNT];
    logic [CIC_W-1:0] comb [STAGE_COUNT];
    logic [CIC_W-1:0] cic_out;
    logic signed [CIC_W-1:0] centred;
    logic signed [CIC_W-1:0] scaled;
    logic over;
    logic [RES_W-1:0] res;

    always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
        integ <= '{default: CIC_RST};
      end else if (mod_en) begin
        integ[0] <= integ[0] + CIC_W'(mod_sync[g]);
        integ[1] <= integ[1] + integ[0];
        integ[2] <= integ[2] + integ[1];
      end
    end

    always_comb begin
      comb[0] = integ[2] - delay[0];
      comb[1] = comb[0] - delay[1];
      comb[2] = comb[1] - delay[2];
    end

    // Comb section at the decimated rate
    always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
        delay <= '{default: CIC_RST};
        cic_out <= CIC_RST;
      end else if (dec_fire) begin
        delay[0] <= integ[2];
        delay[1] <= comb[0];
        delay[2] <= comb[1];
        cic_out <= comb[2];
      end
    end

    always_comb begin
      centred = $signed(cic_out)
              - $signed(CIC_W'(1) << (RES_W - 1 + STAGE_COUNT * 32'(cfg.rate)));
      // Keep the top bits at lower rates
      scaled = centred >>> (STAGE_COUNT * 32'(cfg.rate));
      over = (scaled > $signed(CIC_W'(RES_MAX)));
      // Fifteen grown bits at base ratio
      res = over ? RES_MAX : scaled[RES_W-1:0];
      if (mode.mixed_mode) begin
        ch_word[g] = {FLAG_DATA, res};
      end else if (over) begin
        ch_word[g] = POS_FULL_SCALE;
      end else begin
        ch_word[g] = {res, 1'b0};
      end
    end
  end

  // ==========================================================================
  // Sample hold and FIFO feed
  logic [WORD_W-1:0] hold [NUM_CH];
  logic [2:0] feed_idx;
  logic feeding;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic ser_take;
  logic capture;

  // Samples only leave in data or mixed mode
  assign capture = sample_pending && mode.data_mode;

  // Output words update on the sample event
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hold <= '{default: WORD_RST};
    end else if (capture) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        hold[ch] <= ch_word[ch];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      feeding <= 1'b0;
      feed_idx <= '0;
    end else if (capture) begin
      feeding <= 1'b1;
      feed_idx <= '0;
    end else if (feeding && fifo_in_ready) begin
      feeding <= (feed_idx != 3'(NUM_CH - 1));
      feed_idx <= feed_idx + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sample_event_o <= 1'b0;
      overrun_o <= 1'b0;
    end else begin
      sample_event_o <= capture;
      overrun_o <= capture && feeding;
    end
  end

  sample_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(feeding),
    .in_ready_o(fifo_in_ready),
    .in_data_i(hold[feed_idx]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(ser_take),
    .out_data_o(fifo_out_data)
  );

  // ==========================================================================
  // Serial port
  ser_state_t ser_state;
  logic [WORD_W-1:0] shreg;
  logic [BITCNT_W-1:0] bit_cnt;
  logic rise_next;

  assign ser_take = (ser_state == SER_IDLE) && fifo_out_valid && half_tick;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ser_state <= SER_IDLE;
      shreg <= WORD_RST;
      bit_cnt <= '0;
      rise_next <= 1'b0;
      serial_clk_o <= 1'b0;
      serial_data_o <= 1'b0;
      frame_sync_o <= 1'b0;
      rx_word_o <= WORD_RST;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      unique case (ser_state)
        SER_IDLE: begin
          if (ser_take) begin
            shreg <= fifo_out_data;
            serial_data_o <= fifo_out_data[WORD_W-1];
            frame_sync_o <= 1'b1;
            serial_clk_o <= 1'b0;
            bit_cnt <= '0;
            rise_next <= 1'b1;
            ser_state <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          if (half_tick && rise_next) begin
            serial_clk_o <= 1'b1;
            // Same register shifts in host data
            shreg <= {shreg[WORD_W-2:0], sdi_sync};
            rise_next <= 1'b0;
          end else if (half_tick) begin
            serial_clk_o <= 1'b0;
            frame_sync_o <= 1'b0;
            rise_next <= 1'b1;
            if (bit_cnt == BITCNT_W'(WORD_W - 1)) begin
              rx_word_o <= shreg;
              // Host words accepted in mixed mode
              rx_valid_o <= mode.mixed_mode;
              ser_state <= SER_IDLE;
            end else begin
              bit_cnt <= bit_cnt + 1'b1;
              serial_data_o <= shreg[WORD_W-1];
            end
          end
        end
      endcase
    end
  end

endmodule // sd_decimation_path
`default_nettype wire

// ===== bench/sd_decimation_path_assertions.sv
// Concurrent checks on the ports of the decimation path
`default_nettype none
module sd_decimation_path_assertions
  import sd_path_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [NUM_CH-1:0] modulator_bit_i,
  input wire logic [7:0] control_reg_a_i,
  input wire logic [7:0] control_reg_b_i,
  input wire logic [7:0] control_reg_c_i,
  input wire logic [7:0] control_reg_d_i,
  input wire logic [7:0] control_reg_e_i,
  input wire logic [7:0] control_reg_f_i,
  input wire logic host_sdi_i,
  input wire logic [NUM_CH-1:0][GAIN_W-1:0] gain_db_o,
  input wire logic reference_output_enable_o,
  input wire logic serial_clk_o,
  input wire logic serial_data_o,
  input wire logic frame_sync_o,
  input wire logic [WORD_W-1:0] rx_word_o,
  input wire logic rx_valid_o,
  input wire logic sample_event_o,
  input wire logic overrun_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // ==========================================================================
  // Helper state
  logic fs_q;
  logic sclk_q;
  logic ev_seen;
  logic [4:0] rise_cnt;
  logic [15:0] gap;
  logic [15:0] period;
  logic [7:0] c_q;
  logic [7:0] d_q;
  logic [7:0] f_q;

  // Expected spacing of sample events for the current rate and divider
  assign period = 16'((32'd256 << control_reg_b_i[1:0]) *
    ((control_reg_b_i[6:4] > 3'd3) ? 32'd5 : 32'(control_reg_b_i[6:4]) + 32'd1));

  always_ff @(posedge clk_i) begin
    c_q <= control_reg_c_i;
    d_q <= control_reg_d_i;
    f_q <= control_reg_f_i;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fs_q <= 1'b0;
      sclk_q <= 1'b0;
      rise_cnt <= 5'h10;
      gap <= 16'h0001;
      ev_seen <= 1'b0;
    end else begin
      fs_q <= frame_sync_o;
      sclk_q <= serial_clk_o;
      if (frame_sync_o && !fs_q) begin
        rise_cnt <= 5'h00;
      end else if (serial_clk_o && !sclk_q && rise_cnt != 5'h1f) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
      gap <= sample_event_o ? 16'h0001 : gap + 16'h0001;
      if (sample_event_o) begin
        ev_seen <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Properties
  property p_gain_first;
    $past(resetn_i) |-> gain_db_o[0] == GAIN_DB[d_q[2:0]];
  endproperty
  a_gain_first: assert property (p_gain_first) else $error("gain ch0 wrong");

  property p_gain_last;
    $past(resetn_i) |-> gain_db_o[5] == GAIN_DB[f_q[6:4]];
  endproperty
  a_gain_last: assert property (p_gain_last) else $error("gain ch5 wrong");

  property p_ref_enable;
    $past(resetn_i) |-> reference_output_enable_o == c_q[CRC_REF_BIT];
  endproperty
  a_ref_enable: assert property (p_ref_enable) else $error("ref enable wrong");

  property p_event_spacing;
    sample_event_o && ev_seen |-> gap == period;
  endproperty
  a_event_spacing: assert property (p_event_spacing) else $error("event spacing");

  property p_sixteen_bits;
    $rose(frame_sync_o) |-> rise_cnt == 5'h10;
  endproperty
  a_sixteen_bits: assert property (p_sixteen_bits) else $error("frame not 16 bits");

  property p_no_stray_clock;
    $rose(serial_clk_o) |-> rise_cnt < 5'h10;
  endproperty
  a_no_stray_clock: assert property (p_no_stray_clock) else $error("stray clock");

  property p_data_hold;
    serial_clk_o |-> $stable(serial_data_o);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");

  property p_frame_mode;
    frame_sync_o |-> control_reg_a_i[CRA_DATA_BIT];
  endproperty
  a_frame_mode: assert property (p_frame_mode) else $error("frame in program mode");

  property p_rx_mixed;
    rx_valid_o |-> (control_reg_a_i[0] && control_reg_a_i[1] && rise_cnt == 5'h10)
      ##1 !rx_valid_o;
  endproperty
  a_rx_mixed: assert property (p_rx_mixed) else $error("rx valid misplaced");

  c_event: cover property (sample_event_o);
  c_rx: cover property (rx_valid_o);
  c_frame: cover property ($rose(frame_sync_o));
endmodule // sd_decimation_path_assertions

bind sd_decimation_path sd_decimation_path_assertions u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .modulator_bit_i(modulator_bit_i),
  .control_reg_a_i(control_reg_a_i), .control_reg_b_i(control_reg_b_i),
  .control_reg_c_i(control_reg_c_i), .control_reg_d_i(control_reg_d_i),
  .control_reg_e_i(control_reg_e_i), .control_reg_f_i(control_reg_f_i),
  .host_sdi_i(host_sdi_i), .gain_db_o(gain_db_o),
  .reference_output_enable_o(reference_output_enable_o),
  .serial_clk_o(serial_clk_o), .serial_data_o(serial_data_o),
  .frame_sync_o(frame_sync_o), .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o),
  .sample_event_o(sample_event_o), .overrun_o(overrun_o)
);
`default_nettype wire

// ===== bench/host_dsp_model.sv
// Host serial port model: takes device frames and returns one word per frame
`default_nettype none
module host_dsp_model
  import sd_path_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic serial_clk_i,
  input wire logic serial_data_i,
  input wire logic frame_sync_i,
  input wire logic [WORD_W-1:0] tx_word_i,
  output logic host_sdi_o,
  output logic [WORD_W-1:0] rx_word_o,
  output logic rx_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic fs_q;
  logic in_frame;
  logic [4:0] bit_cnt;
  logic [WORD_W-1:0] shift_in;
  logic [WORD_W-1:0] shift_out;

  always_ff @(posedge clk_i) begin
    sclk_q <= serial_clk_i;
    fs_q <= frame_sync_i;
    rx_done_o <= 1'b0;
    if (!resetn_i) begin
      in_frame <= 1'b0;
      host_sdi_o <= 1'b0;
    end else if (frame_sync_i && !fs_q) begin
      in_frame <= 1'b1;
      bit_cnt <= 5'h00;
      {host_sdi_o, shift_out} <= {tx_word_i, 1'b0};
    end else if (in_frame && serial_clk_i && !sclk_q) begin
      shift_in <= {shift_in[WORD_W-2:0], serial_data_i};
      bit_cnt <= bit_cnt + 5'h01;
    end else if (in_frame && !serial_clk_i && sclk_q) begin
      if (bit_cnt == 5'h10) begin
        in_frame <= 1'b0;
        rx_word_o <= shift_in;
        rx_done_o <= 1'b1;
        host_sdi_o <= ~host_sdi_o;
      end else begin
        {host_sdi_o, shift_out} <= {shift_out, 1'b0};
      end
    end else if (!in_frame) begin
      // Released line keeps changing between frames
      host_sdi_o <= ~host_sdi_o;
    end
  end
endmodule // host_dsp_model
`default_nettype wire

// ===== bench/sd_decimation_path_tb_top.sv
// Self-checking testbench for the sigma-delta decimation path
`default_nettype none
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module sd_decimation_path_tb_top import sd_path_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] mod_base = 6'h00;
  logic [5:0] mod = 6'h00;
  logic alt = 1'b0;
  logic tgl = 1'b0;
  logic [7:0] control_reg_a = 8'h00, crb = 8'h00, crc = 8'h00, control_reg_d = 8'h00, control_reg_e = 8'h00, control_reg_f = 8'h00;
  logic [15:0] host_tx = 16'ha5c3;
  logic sdi, ref_en, sclk, sdo, fs, rx_valid, sample_event, overrun, host_done;
  logic [NUM_CH-1:0][GAIN_W-1:0] gain_db;
  logic [15:0] rx_word, host_word, rx_last;
  logic [15:0] words[$];
  logic [5:0] t_mod [6] = '{6'h01, 6'h3e, 6'h00, 6'h15, 6'h00, 6'h05};
  logic [1:0] t_rate [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
  // Master divider codes (6 clamps to /5) and serial half-period selects per test
  logic [2:0] t_div [6] = '{3'h6, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [1:0] t_sclk [6] = '{2'h0, 2'h1, 2'h0, 2'h3, 2'h0, 2'h2};
  int error_cnt = 0, total_checks = 0, cyc = 0, ev_cnt = 0, ovr_cnt = 0, rxv_cnt = 0;

  sd_decimation_path u_dut (.clk_i(clk), .resetn_i(resetn), .modulator_bit_i(mod),
    .control_reg_a_i(control_reg_a), .control_reg_b_i(crb), .control_reg_c_i(crc),
    .control_reg_d_i(control_reg_d), .control_reg_e_i(control_reg_e), .control_reg_f_i(control_reg_f),
    .host_sdi_i(sdi), .gain_db_o(gain_db), .reference_output_enable_o(ref_en),
    .serial_clk_o(sclk), .serial_data_o(sdo), .frame_sync_o(fs), .rx_word_o(rx_word),
    .rx_valid_o(rx_valid), .sample_event_o(sample_event), .overrun_o(overrun));

  host_dsp_model u_host (.clk_i(clk), .resetn_i(resetn), .serial_clk_i(sclk),
    .serial_data_i(sdo), .frame_sync_i(fs), .tx_word_i(host_tx), .host_sdi_o(sdi),
    .rx_word_o(host_word), .rx_done_o(host_done));

  always #2 clk = ~clk;

  // ==========================================================================
  // Monitors and stimulus pattern
  always @(posedge clk) begin
    if (cyc % 8 == 0) tgl <= ~tgl;
    mod <= alt ? {6{tgl}} : mod_base;
    if (host_done) words.push_back(host_word);
    if (sample_event) ev_cnt++;
    if (overrun) ovr_cnt++;
    if (rx_valid) begin
      rxv_cnt++;
      rx_last = rx_word;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end

  // ==========================================================================
  // Helpers
  function automatic logic [5:0] gdb(input int c);
    return (c < 4) ? 6'(6 * c) : 6'(20 + 6 * (c - 4));
  endfunction

  function automatic logic [15:0] exp_word(input logic b, input logic a, input logic m);
    if (a) return 16'h0000;
    if (m) return b ? 16'h3fff : 16'h4000;
    return b ? 16'h7fff : 16'h8000;
  endfunction

  task automatic setup(input logic [7:0] a, input logic [7:0] b);
    resetn <= 1'b0;
    control_reg_a <= a;
    crb <= b;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
  endtask

  task automatic wait_events(input int n);
    int start;
    start = ev_cnt;
    for (int t = 0; t < 20000 && ev_cnt < start + n; t++) @(posedge clk);
  endtask

  task automatic wait_words(input int n);
    for (int t = 0; t < 20000 && words.size() < n; t++) @(posedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic m;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    for (int g = 0; g < 8; g++) begin
      control_reg_d <= {1'b0, 3'(7 - g), 1'b0, 3'(g)};
      control_reg_e <= {1'b0, 3'(7 - g), 1'b0, 3'(g)};
      control_reg_f <= {1'b0, 3'(7 - g), 1'b0, 3'(g)};
      crc <= (g % 2) ? 8'h40 : 8'h00;
      repeat (3) @(posedge clk);
      for (int ch = 0; ch < NUM_CH; ch++) `CHECK(gain_db[ch], gdb((ch % 2) ? 7 - g : g))
      `CHECK(ref_en, 1'(g % 2))
    end
    repeat (600) @(posedge clk);
    `CHECK(ev_cnt, 0)
    `CHECK(words.size(), 0)
    $display("test gain and program mode done");
    for (int i = 0; i < 6; i++) begin
      m = (i == 5);
      mod_base <= t_mod[i];
      alt <= (i == 4);
      setup(m ? 8'h03 : 8'h01, {1'b0, t_div[i], t_sclk[i], t_rate[i]});
      wait_events(4);
      words.delete();
      ovr_cnt = 0;
      rxv_cnt = 0;
      wait_words(6);
      for (int c = 0; c < NUM_CH; c++) begin
        `CHECK(words[c], exp_word(t_mod[i][c], i == 4, m))
      end
      `CHECK(ovr_cnt, 0)
      `CHECK(rxv_cnt > 0, m)
      if (m) `CHECK(rx_last, 16'ha5c3)
      $display("test conversion %0d done", i);
    end
    summarize();
  end
endmodule // sd_decimation_path_tb_top
`default_nettype wire
